// ==== rtl/iox_device.sv ====
`timescale 1ns/1ns
module iox_device (
  input  wire logic       clk,             // System clock, 20 MHz.
  input  wire logic       rst_b,           // Power-on reset, active low.
  input  wire logic       ce,              // Clock enable, low freezes.
  input  wire logic       reset_pin_b,     // External reset pin, low.
  input  wire logic       addr_strap_low,  // Address strap, low bit.
  input  wire logic       addr_strap_high, // Address strap, high bit.
  input  wire logic [7:0] port_pin_level,  // Levels seen on port pins.
  output logic      [7:0] high_side_driver, // Pull pin to supply.
  output logic      [7:0] low_side_driver,  // Pull pin to ground.
  iox_link_if.device      link             // Serial link to master.
);
  import iox_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything that arrives from outside.

  logic [12:0]       sync_a;
  logic [12:0]       sync_b;
  logic              scl_prev;
  logic              sda_prev;
  iox_dev_state_type state;
  logic [7:0]        shift_data;
  logic [3:0]        bit_cnt;
  logic              rw_read;
  logic              master_ack;
  logic              sda_oe_q;
  logic [7:0]        drive_level_latch;
  logic [7:0]        input_invert_select;
  logic [7:0]        pin_direction_select;
  logic [7:0]        register_selector;
  logic [7:0]        int_ref;
  logic              ref_loaded;
  logic              int_oe_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= DEV_SYNC_RST;
      sync_b <= DEV_SYNC_RST;
    end else if (ce) begin
      sync_a <= {link.scl, link.sda, reset_pin_b, addr_strap_high,
                 addr_strap_low, port_pin_level};
      sync_b <= sync_a;
    end
  end

  wire       scl_s     = sync_b[SYNC_SCL];
  wire       sda_s     = sync_b[SYNC_SDA];
  // A short reset pulse is only seen if it spans the synchroniser.
  wire       rst_pin_s = sync_b[SYNC_RST_PIN];
  wire [7:0] pins_s    = sync_b[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions and decodes.

  wire scl_rise   = scl_s & ~scl_prev;
  wire scl_fall   = ~scl_s & scl_prev;
  wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;
  wire byte_full  = (bit_cnt == BYTE_BITS);
  wire soft_clear = ~rst_pin_s;

  wire [6:0] own_addr = {FIXED_ADDR, sync_b[SYNC_STRAP_HI],
                         sync_b[SYNC_STRAP_LO]};
  wire       addr_hit = (shift_data[7:1] == own_addr);

  wire cmd_done  = (state == ST_CMD) & scl_fall & byte_full;
  wire data_done = (state == ST_WRITE) & scl_fall & byte_full;
  // Code 00h has no write strobe at all, so input writes vanish.
  wire wr_latch  = data_done & (register_selector == REG_LATCH);
  wire wr_invert = data_done & (register_selector == REG_INVERT);
  wire wr_dir    = data_done & (register_selector == REG_DIR);

  // Inversion only applies to pins that are inputs.
  wire [7:0] pin_level_sample =
    pins_s ^ (input_invert_select & pin_direction_select);

  // Edges on output pins are masked out of the comparison.
  wire int_pending = |((pins_s ^ int_ref) & pin_direction_select);
  wire read_ack_clear = (state == ST_ACK_READ) & scl_rise &
                        (register_selector == REG_INPUT);

  function automatic logic [7:0] read_value(input logic [7:0] s, p, l, i, d);
    unique case (s)
      REG_INPUT:  read_value = p;
      REG_LATCH:  read_value = l;
      REG_INVERT: read_value = i;
      REG_DIR:    read_value = d;
      default:    read_value = 8'h00;
    endcase
  endfunction
  wire [7:0] rd_byte = read_value(register_selector, pin_level_sample,
    drive_level_latch, input_invert_select, pin_direction_select);

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (ce) begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      shift_data <= 8'h00;
      bit_cnt    <= 4'h0;
      rw_read    <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (ce) begin
      if (soft_clear || stop_cond) begin
        state    <= ST_IDLE;
        bit_cnt  <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (start_cond) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_CMD, ST_WRITE: begin
            if (scl_rise) begin
              shift_data <= {shift_data[6:0], sda_s};
              bit_cnt    <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_full) begin
              bit_cnt <= 4'h0;
              if (state != ST_ADDR) begin
                state    <= (state == ST_CMD) ? ST_ACK_CMD : ST_ACK_WRITE;
                sda_oe_q <= 1'b1;
              end else if (addr_hit) begin
                state    <= ST_ACK_ADDR;
                sda_oe_q <= 1'b1;
                rw_read  <= shift_data[0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (scl_fall && rw_read) begin
              state      <= ST_READ;
              shift_data <= rd_byte;
              sda_oe_q   <= ~rd_byte[7];
            end else if (scl_fall) begin
              state    <= ST_CMD;
              sda_oe_q <= 1'b0;
            end
          end
          ST_ACK_CMD, ST_ACK_WRITE: begin
            // Every further data byte goes to the same register.
            if (scl_fall) begin
              state    <= ST_WRITE;
              sda_oe_q <= 1'b0;
            end
          end
          ST_READ: begin
            if (scl_fall && bit_cnt == LAST_BIT) begin
              state    <= ST_ACK_READ;
              bit_cnt  <= 4'h0;
              sda_oe_q <= 1'b0;
            end else if (scl_fall) begin
              bit_cnt    <= bit_cnt + 4'h1;
              shift_data <= {shift_data[6:0], 1'b0};
              sda_oe_q   <= ~shift_data[6];
            end
          end
          ST_ACK_READ: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall && master_ack) begin
              state      <= ST_READ;
              shift_data <= rd_byte;
              sda_oe_q   <= ~rd_byte[7];
            end else if (scl_fall) begin
              state <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_level_latch    <= RST_LATCH;
      input_invert_select  <= RST_INVERT;
      pin_direction_select <= RST_DIR;
      register_selector    <= RST_SELECTOR;
    end else if (ce) begin
      if (soft_clear) begin
        drive_level_latch    <= RST_LATCH;
        input_invert_select  <= RST_INVERT;
        pin_direction_select <= RST_DIR;
        register_selector    <= RST_SELECTOR;
      end else begin
        if (cmd_done) begin
          register_selector <= shift_data;
        end
        if (wr_latch) begin
          drive_level_latch <= shift_data;
        end
        if (wr_invert) begin
          input_invert_select <= shift_data;
        end
        if (wr_dir) begin
          pin_direction_select <= shift_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and interrupt.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_side_driver <= RST_DRIVER;
      low_side_driver  <= RST_DRIVER;
      int_ref          <= 8'h00;
      ref_loaded       <= 1'b0;
      int_oe_q         <= 1'b0;
    end else if (ce) begin
      if (soft_clear) begin
        high_side_driver <= RST_DRIVER;
        low_side_driver  <= RST_DRIVER;
        ref_loaded       <= 1'b0;
        int_oe_q         <= 1'b0;
      end else begin
        high_side_driver <= ~pin_direction_select & drive_level_latch;
        low_side_driver  <= ~pin_direction_select & ~drive_level_latch;
        ref_loaded       <= 1'b1;
        // The reference is taken at release so no edge is seen then.
        if (!ref_loaded || read_ack_clear) begin
          int_ref <= pins_s;
        end
        int_oe_q <= ref_loaded & ~read_ack_clear & int_pending;
      end
    end
  end

  assign link.sda_oe_dev = sda_oe_q;
  assign link.int_oe_dev = int_oe_q;

endmodule

// ==== shared/iox_pkg.sv ====
package iox_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Device address and register codes.
  localparam logic [4:0]  FIXED_ADDR    = 5'h1c;
  localparam logic [7:0]  REG_INPUT     = 8'h00;
  localparam logic [7:0]  REG_LATCH     = 8'h01;
  localparam logic [7:0]  REG_INVERT    = 8'h02;
  localparam logic [7:0]  REG_DIR       = 8'h03;
  localparam logic [7:0]  RST_LATCH     = 8'hff;
  localparam logic [7:0]  RST_INVERT    = 8'h00;
  localparam logic [7:0]  RST_DIR       = 8'hff;
  localparam logic [7:0]  RST_SELECTOR  = 8'h00;
  localparam logic [7:0]  RST_DRIVER    = 8'h00;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;

  //////////////////////////////////////////////////////////////////////////
  // Device and controller input synchroniser layout.
  localparam logic [12:0] DEV_SYNC_RST  = 13'h1800;
  localparam int          SYNC_SCL      = 12;
  localparam int          SYNC_SDA      = 11;
  localparam int          SYNC_RST_PIN  = 10;
  localparam int          SYNC_STRAP_HI = 9;
  localparam int          SYNC_STRAP_LO = 8;
  localparam logic [1:0]  HOST_SYNC_RST = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Controller register map and fields.
  localparam logic [7:0]  HOST_CMD      = 8'h00;
  localparam logic [7:0]  HOST_WDATA    = 8'h04;
  localparam logic [7:0]  HOST_STATUS   = 8'h08;
  localparam logic [7:0]  HOST_RDATA    = 8'h0c;
  localparam int          CMD_STRAP_LSB = 8;
  localparam int          CMD_READ_BIT  = 12;
  localparam int          STATUS_BUSY   = 0;
  localparam int          STATUS_NACK   = 1;
  localparam int          STATUS_INT    = 2;

  //////////////////////////////////////////////////////////////////////////
  // Serial clock timing made by the controller.
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          SCL_PERIOD_NS = 1000;
  localparam int          QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [2:0]  WRITE_STOP_STEP = 3'h4;
  localparam logic [2:0]  READ_STOP_STEP  = 3'h6;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ACK_ADDR  = 4'b0010,
    ST_CMD       = 4'b0011,
    ST_ACK_CMD   = 4'b0100,
    ST_WRITE     = 4'b0101,
    ST_ACK_WRITE = 4'b0110,
    ST_READ      = 4'b0111,
    ST_ACK_READ  = 4'b1000
  } iox_dev_state_type;

  typedef enum logic [1:0] {
    STEP_START = 2'b00,
    STEP_TX    = 2'b01,
    STEP_RX    = 2'b10,
    STEP_STOP  = 2'b11
  } iox_step_type;

endpackage

// ==== shared/iox_link_if.sv ====
`timescale 1ns/1ns
interface iox_link_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic int_oe_dev;
  logic scl;
  logic sda;
  logic int_n;

  // Open-drain wires: any enable pulls the line low, else the pull-up wins.
  assign scl   = ~scl_oe_host;
  assign sda   = ~(sda_oe_host | sda_oe_dev);
  assign int_n = ~int_oe_dev;

  modport device (
    input  scl,
    input  sda,
    output sda_oe_dev,
    output int_oe_dev
  );

  modport host (
    output scl_oe_host,
    output sda_oe_host,
    input  sda,
    input  int_n
  );
endinterface

// ==== rtl/iox_host.sv ====
`timescale 1ns/1ns
module iox_host #(
  parameter int QUARTER = iox_pkg::QUARTER_CYCLES // Clocks per SCL quarter.
) (
  input  wire logic        clk,     // System clock, 20 MHz.
  input  wire logic        rst_b,   // Reset, active low.
  input  wire logic        ce,      // Clock enable, low freezes.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB enable.
  input  wire logic        pwrite,  // APB direction, high writes.
  input  wire logic [7:0]  paddr,   // APB byte address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output logic      [31:0] prdata,  // APB read data.
  output logic             pready,  // APB ready.
  output logic             pslverr, // APB error, unmapped address.
  iox_link_if.host         link     // Serial link to the device.
);
  import iox_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [1:0]   sync_a;
  logic [1:0]   sync_b;
  logic [7:0]   cmd_code;
  logic [1:0]   cmd_strap;
  logic         cmd_read;
  logic [7:0]   wdata;
  logic [7:0]   rdata;
  logic         busy;
  logic         nack;
  logic         launch;
  logic [7:0]   div_cnt;
  logic [1:0]   phase;
  logic [2:0]   step;
  logic [3:0]   bit_idx;
  logic [7:0]   rx_shift;
  logic         ack_bit;
  logic         scl_oe_q;
  logic         sda_oe_q;

  wire sda_s   = sync_b[1];
  wire int_s   = ~sync_b[0];
  wire setup   = psel & ~penable;
  wire apb_wr  = psel & penable & pready & pwrite;
  wire hit_cmd = (paddr == HOST_CMD);
  wire hit_wd  = (paddr == HOST_WDATA);
  wire hit_st  = (paddr == HOST_STATUS);
  wire hit_rd  = (paddr == HOST_RDATA);
  wire mapped  = hit_cmd | hit_wd | hit_st | hit_rd;
  wire nack_clr = apb_wr & hit_st & pwdata[STATUS_NACK];

  wire [31:0] status_word = {29'h0, int_s, nack, busy};
  wire [31:0] apb_rd =
    hit_cmd ? {19'h0, cmd_read, 2'h0, cmd_strap, cmd_code} :
    hit_wd  ? {24'h0, wdata} :
    hit_st  ? status_word :
    hit_rd  ? {24'h0, rdata} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= HOST_SYNC_RST;
      sync_b <= HOST_SYNC_RST;
    end else if (ce) begin
      sync_a <= {link.sda, link.int_n};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      cmd_code  <= 8'h00;
      cmd_strap <= 2'h0;
      cmd_read  <= 1'b0;
      wdata     <= 8'h00;
      launch    <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? apb_rd : 32'h0000_0000;
      // A command written while busy is dropped.
      launch  <= apb_wr & hit_cmd & ~busy;
      if (apb_wr && hit_cmd && !busy) begin
        cmd_code  <= pwdata[7:0];
        cmd_strap <= pwdata[CMD_STRAP_LSB+1:CMD_STRAP_LSB];
        cmd_read  <= pwdata[CMD_READ_BIT];
      end
      if (apb_wr && hit_wd) begin
        wdata <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer: start, address, command, then data or restart and read.

  function automatic iox_step_type step_kind(input logic rd,
                                             input logic [2:0] st);
    step_kind = STEP_TX;
    if (st == 3'h0 || (rd && st == 3'h3)) begin
      step_kind = STEP_START;
    end else if (st == (rd ? READ_STOP_STEP : WRITE_STOP_STEP)) begin
      step_kind = STEP_STOP;
    end else if (rd && st == 3'h5) begin
      step_kind = STEP_RX;
    end
  endfunction

  wire [6:0] dev_addr = {FIXED_ADDR, cmd_strap};
  wire [7:0] cur_byte = (step == 3'h1) ? {dev_addr, 1'b0} :
                        (step == 3'h2) ? cmd_code :
                        cmd_read ? {dev_addr, 1'b1} : wdata;
  iox_step_type kind;
  assign kind = step_kind(cmd_read, step);
  wire       tick     = (div_cnt == 8'h00);
  wire       data_bit = ~bit_idx[3];
  wire [2:0] bit_pos  = ~bit_idx[2:0];
  wire       nack_set = busy & tick & (phase == 2'h2) & (kind == STEP_TX) &
                        ~data_bit & sda_s;
  wire [2:0] stop_step = cmd_read ? READ_STOP_STEP : WRITE_STOP_STEP;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy     <= 1'b0;
      nack     <= 1'b0;
      rdata    <= 8'h00;
      div_cnt  <= 8'h00;
      phase    <= 2'h0;
      step     <= 3'h0;
      bit_idx  <= 4'h0;
      rx_shift <= 8'h00;
      ack_bit  <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      // A new refusal in the clearing cycle still shows.
      nack <= nack_set | (nack & ~nack_clr);
      if (launch) begin
        busy    <= 1'b1;
        div_cnt <= 8'(QUARTER - 1);
        phase   <= 2'h0;
        step    <= 3'h0;
        bit_idx <= 4'h0;
      end else if (busy) begin
        div_cnt <= tick ? 8'(QUARTER - 1) : div_cnt - 8'h01;
      end
      if (busy && tick && !launch) begin
        phase <= phase + 2'h1;
        unique case (kind)
          STEP_START: begin
            if (phase == 2'h0) sda_oe_q <= 1'b0;
            if (phase == 2'h1) scl_oe_q <= 1'b0;
            if (phase == 2'h2) sda_oe_q <= 1'b1;
            if (phase == 2'h3) scl_oe_q <= 1'b1;
            if (phase == 2'h3) step <= step + 3'h1;
          end
          STEP_STOP: begin
            if (phase == 2'h0) sda_oe_q <= 1'b1;
            if (phase == 2'h1) scl_oe_q <= 1'b0;
            if (phase == 2'h2) sda_oe_q <= 1'b0;
            if (phase == 2'h3) busy <= 1'b0;
          end
          STEP_TX, STEP_RX: begin
            if (phase == 2'h0) begin
              sda_oe_q <= (kind == STEP_TX) & data_bit & ~cur_byte[bit_pos];
            end
            if (phase == 2'h1) scl_oe_q <= 1'b0;
            if (phase == 2'h2 && data_bit) begin
              rx_shift <= {rx_shift[6:0], sda_s};
            end
            if (phase == 2'h2 && !data_bit) ack_bit <= sda_s;
            if (phase == 2'h3) begin
              scl_oe_q <= 1'b1;
              bit_idx  <= data_bit ? bit_idx + 4'h1 : 4'h0;
              if (!data_bit && kind == STEP_RX) rdata <= rx_shift;
              if (!data_bit) begin
                step <= (kind == STEP_TX && ack_bit) ? stop_step
                                                      : step + 3'h1;
              end
            end
          end
        endcase
      end
    end
  end

  assign link.scl_oe_host = scl_oe_q;
  assign link.sda_oe_host = sda_oe_q;

endmodule

// ==== sim/iox_props.sv ====
`timescale 1ns/1ns
module iox_props (
  input wire logic       clk,              // System clock.
  input wire logic       rst_b,            // Reset, active low.
  input wire logic       reset_pin_b,      // Device reset pin.
  input wire logic       scl,              // Serial clock wire.
  input wire logic       sda_oe_dev,       // Device pulls data low.
  input wire logic       int_oe_dev,       // Device pulls int low.
  input wire logic [7:0] high_side_driver, // Pin drive high.
  input wire logic [7:0] low_side_driver   // Pin drive low.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  sequence s_pin_rst;
    !reset_pin_b[*4];
  endsequence
  sequence s_all_out;
    (&(high_side_driver | low_side_driver))[*8];
  endsequence
  a_drv_excl: assert property (
    !(|(high_side_driver & low_side_driver))) else $error("both drivers");
  a_drv_reset: assert property (
    $rose(rst_b) |-> (high_side_driver | low_side_driver) == 8'h00)
    else $error("drivers on after reset");
  a_int_reset: assert property (
    $rose(rst_b) |-> !int_oe_dev && !sda_oe_dev) else $error("bus not idle");
  a_pin_clear: assert property (
    s_pin_rst |-> ##[0:3] (high_side_driver | low_side_driver) == 8'h00
    && !int_oe_dev) else $error("reset pin did not clear");
  a_ack_scl_low: assert property (
    $changed(sda_oe_dev) |-> !scl) else $error("data moved with clock high");
  a_ack_hold: assert property (
    $rose(sda_oe_dev) |-> sda_oe_dev[*8]) else $error("data held too short");
  // Writes land in the ack phase, so a write never moves a pin while the clock is up.
  a_drv_scl_low: assert property (
    $changed(high_side_driver) && reset_pin_b |-> !scl)
    else $error("pin drive moved with clock high");
  a_int_outputs: assert property (
    s_all_out |-> !$rose(int_oe_dev)) else $error("output pin interrupt");
endmodule

// ==== sim/iox_tb.sv ====
`timescale 1ns/1ns
module iox_tb;
  import iox_pkg::*;
  logic        clk = 0;
  logic        rst_b = 0;
  logic        rpin_b = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        want = 0;
  logic [1:0]  strap = 2'h0;
  logic [1:0]  cs = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  ext = 8'h00;
  logic [7:0]  v1, v2, v3, hs, ls;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, last, rnd;
  logic        pready, pslverr;
  wire  [7:0]  pins = hs | (~ls & ext);
  logic [32:0] q[$];
  int          num_errors = 0;
  int          n_compared = 0;
  iox_link_if link_if ();
  iox_device iox_device_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .reset_pin_b(rpin_b), .addr_strap_low(strap[0]),
    .addr_strap_high(strap[1]), .port_pin_level(pins),
    .high_side_driver(hs), .low_side_driver(ls), .link(link_if));
  iox_host #(.QUARTER(5)) iox_host_inst (.clk(clk), .rst_b(rst_b),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  iox_props iox_props_inst (.clk(clk), .rst_b(rst_b),
    .reset_pin_b(rpin_b), .scl(link_if.scl),
    .sda_oe_dev(link_if.sda_oe_dev), .int_oe_dev(link_if.int_oe_dev),
    .high_side_driver(hs), .low_side_driver(ls));
  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task finish_test;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  always @(posedge clk) if (want && pready === 1'b1) begin
    check({pslverr, prdata}, q.pop_front());
  end
  // Request held until pready is seen; the answer is taken at that edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic ck,
                     input logic [32:0] e);
    int k = 0;
    if (ck) q.push_back(e);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    want <= ck;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && k++ < 20);
    if (k > 20) num_errors++;
    last = prdata;
    psel <= 0;
    penable <= 0;
    want <= 0;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] c,
                      input logic [7:0] d);
    int k = 0;
    apb(1, HOST_WDATA, {24'h00_0000, d}, 0, '0);
    apb(1, HOST_CMD, {19'h0_0000, rd, 2'h0, cs, c}, 0, '0);
    // Busy only shows one cycle after the command is taken, the cycle after launch rises.
    repeat (4) @(posedge clk);
    do apb(0, HOST_STATUS, '0, 0, '0);
    while (last[STATUS_BUSY] !== 1'b0 && k++ < 400);
    if (k > 400) num_errors++;
  endtask
  task dw(input logic [7:0] c, input logic [7:0] d);
    xfer(0, c, d);
  endtask
  task dr(input logic [7:0] c, input logic [7:0] e);
    xfer(1, c, 8'h00);
    apb(0, HOST_RDATA, '0, 1, {25'h000_0000, e});
  endtask
  task stat(input logic [32:0] e);
    apb(0, HOST_STATUS, '0, 1, e);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test;
  end
  initial begin
    rnd = 32'h0000_c4f3;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    repeat (8) @(posedge clk);
    dr(REG_LATCH, RST_LATCH);
    dr(REG_INVERT, RST_INVERT);
    dr(REG_DIR, RST_DIR);
    rnd = lfsr(rnd);
    v1 = rnd[7:0];
    ext <= v1;
    dr(REG_INPUT, v1);
    ext <= v1 ^ 8'h10;
    repeat (20) @(posedge clk);
    stat(33'h0_0000_0004);
    dr(REG_INPUT, v1 ^ 8'h10);
    stat('0);
    rnd = lfsr(rnd);
    v2 = rnd[7:0];
    dw(REG_INVERT, v2);
    dr(REG_INPUT, v1 ^ 8'h10 ^ v2);
    rnd = lfsr(rnd);
    v3 = rnd[7:0];
    dw(REG_DIR, 8'h00);
    dw(REG_LATCH, v3);
    ext <= ~ext;
    dr(REG_INPUT, v3);
    stat('0);
    dw(REG_DIR, 8'hf0);
    dr(REG_INPUT, ((v3 & 8'h0f) | (ext & 8'hf0)) ^ (v2 & 8'hf0));
    dw(REG_INPUT, ~v3);
    dw(8'h05, 8'h00);
    dr(REG_LATCH, v3);
    dr(8'h05, 8'h00);
    strap <= 2'h2;
    cs = 2'h1;
    dw(REG_LATCH, 8'h00);
    stat(33'h0_0000_0002);
    apb(1, HOST_STATUS, 32'h0000_0002, 0, '0);
    stat('0);
    cs = 2'h2;
    dr(REG_LATCH, v3);
    rpin_b <= 0;
    repeat (4) @(posedge clk);
    rpin_b <= 1;
    repeat (8) @(posedge clk);
    dr(REG_LATCH, RST_LATCH);
    dr(REG_DIR, RST_DIR);
    apb(0, 8'h10, '0, 1, {1'b1, 32'h0000_0000});
    finish_test;
  end
endmodule
